// >>> include/rtcfg_defines.svh
// constants for the terminal buffer and time tag configuration block
`ifndef RTCFG_DEFINES_SVH
`define RTCFG_DEFINES_SVH
// register byte offsets
`define OFS_CFG2 5'h00
`define OFS_CTRL 5'h04
`define OFS_CMD 5'h08
`define OFS_TTAG 5'h0c
`define OFS_STAT 5'h10
// terminal_config_two fields
`define CFG2_RESET 16'h0000
`define B_PAR_EN 14
`define B_BUSY_EN 13
`define B_DBUF_EN 12
`define B_SKIP_BAD 11
`define B_PAGE_OFF 10
`define B_RES_HI 9
`define B_RES_LO 7
`define B_EXT_MGMT 1
// control, command and status fields
`define B_ENH_MODE 0
`define B_RT_MODE 1
`define B_TT_STEP 4
`define B_PERR 0
// command word fields and the broadcast terminal address
`define CMD_ADDR_HI 15
`define CMD_ADDR_LO 11
`define CMD_TR 10
`define CMD_SA_HI 9
`define CMD_SA_LO 5
`define CMD_BIT_HI 8
`define BCST_ADDR 5'h1f
// busy table base word and memory mode test
`define BUSY_BASE 16'h0240
`define SA_DBUF_BIT 15
`define MM_HI 2
`define MM_LO 0
`define MM_SINGLE 3'h0
// time tag codes and timing
`define RES_FINEST 3'h5
`define RES_TEST 3'h6
`define RES_EXT 3'h7
`define CLK_PERIOD_NS 10
`define TT_FINEST_NS 2000
`endif

// >>> include/rtcfg_pkg.sv
// types shared by the terminal buffer and time tag configuration block
package rtcfg_pkg;
  typedef enum logic [0:0] {BUSY_IDLE, BUSY_FETCH} busy_state_t;
  typedef logic [15:0] word_t;
  typedef logic [2:0] res_code_t;
endpackage : rtcfg_pkg

// >>> src/rt_buffer_and_time_tag_config.sv
// configuration register and buffer/time tag control for a 1553 terminal
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "rtcfg_defines.svh"
// Overview of operation
// - large-memory parts generate and check a seventeenth parity bit
// - busy table and receive double buffer act only in enhanced mode
// - busy table is eight reserved words indexed by bcst, t/r, subaddress
// - a set busy table entry puts the busy bit in the status reply
// - with busy table off the table is ignored, words are free memory
// - double buffer enable zero means no receive subaddress is double buffered
// - enable one, enhanced management off: all receive subaddresses double buffered
// - both on: double buffer only if control word top bit and mode 000
// - skip field clear: pointer advances after every message, valid or not
// - skip field clear: rollover raised when lower boundary word accessed
// - skip field set: pointer holds after invalid receive or broadcast
// - skip field set: rollover only at end of good message touching last word
// - page wrap on: block addresses wrap within their 256-word page
// - page wrap off: block addresses carry into the next page
// - command stack always wraps at its configured size
// - terminal mode, page wrap off: subaddress circular buffers are full memory
// - resolution codes zero to five give 64 down to 2 us per count
// - code six is test mode, code seven counts an external clock
// - test mode counts only on host writes of the test step bit
module rt_buffer_and_time_tag_config #(
  parameter int TICK_FINEST_CYCLES = `TT_FINEST_NS / `CLK_PERIOD_NS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic cmd_valid_in,
  input wire logic [15:0] cmd_word_in,
  output logic busy_rd_req_out,
  output logic [15:0] busy_rd_addr_out,
  input wire logic busy_rd_ack_in,
  input wire rtcfg_pkg::word_t busy_rd_data_in,
  output logic busy_bit_out,
  output logic busy_done_out,
  input wire rtcfg_pkg::word_t sa_ctrl_in,
  output logic rx_dual_buf_out,
  input wire logic msg_done_in,
  input wire logic msg_tx_in,
  input wire logic msg_valid_in,
  input wire logic boundary_hit_in,
  input wire logic last_loc_in,
  output logic ptr_adv_out,
  output logic rollover_out,
  input wire rtcfg_pkg::word_t addr_cur_in,
  input wire logic addr_stack_in,
  input wire logic [1:0] stack_size_in,
  output logic [15:0] addr_next_out,
  output logic circ_full_mem_out,
  input wire rtcfg_pkg::word_t ram_wdata_in,
  output logic ram_wpar_out,
  input wire logic ram_rd_valid_in,
  input wire rtcfg_pkg::word_t ram_rdata_in,
  input wire logic ram_rpar_in,
  input wire logic tag_clk_in,
  output logic [15:0] time_tag_out
);
  import rtcfg_pkg::*;

  // ----------------------------------------
  // registers and helpers
  // ----------------------------------------
  word_t cfg2_reg;
  logic [1:0] ctrl_reg;
  logic perr_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  busy_state_t bstate_reg;
  logic [3:0] bbit_reg;
  logic breq_reg, bbit_out_reg, bdone_reg;
  logic dbuf_reg, padv_reg, roll_reg, wpar_reg, full_reg;
  word_t anext_reg, ttag_reg;
  logic [12:0] pre_reg;
  logic [2:0] tclk_reg;
  logic step_reg;

  // even parity over a word; used for writes and checks
  function automatic logic par_of(input word_t w);
    par_of = ^w;
  endfunction : par_of

  // divider period for a resolution code, finest code is one unit
  function automatic logic [12:0] period_of(input res_code_t c);
    logic [2:0] sh;
    sh = `RES_FINEST - c;
    period_of = 13'(TICK_FINEST_CYCLES << sh);
  endfunction : period_of

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // one wait state: the request is seen with wait high, answered next edge
  wire req_w = avs_read_in | avs_write_in;
  wire take_w = req_w & ~wait_reg;
  wire wr_w = avs_write_in & take_w;
  wire wr_cfg_w = wr_w & (avs_address_in == `OFS_CFG2);
  wire wr_ctrl_w = wr_w & (avs_address_in == `OFS_CTRL);
  wire wr_cmd_w = wr_w & (avs_address_in == `OFS_CMD);
  wire wr_stat_w = wr_w & (avs_address_in == `OFS_STAT);
  wire [31:0] rd_mux_w =
    (avs_address_in == `OFS_CFG2) ? {16'h0000, cfg2_reg} :
    (avs_address_in == `OFS_CTRL) ? {30'h00000000, ctrl_reg} :
    (avs_address_in == `OFS_TTAG) ? {16'h0000, ttag_reg} :
    (avs_address_in == `OFS_STAT) ? {31'h00000000, perr_reg} : 32'h00000000;

  // effective field values
  wire enh_w = ctrl_reg[`B_ENH_MODE];
  wire rt_w = ctrl_reg[`B_RT_MODE];
  wire busy_en_w = cfg2_reg[`B_BUSY_EN] & enh_w;
  wire dbuf_en_w = cfg2_reg[`B_DBUF_EN] & enh_w;
  wire par_en_w = cfg2_reg[`B_PAR_EN] & enh_w;
  wire skip_w = cfg2_reg[`B_SKIP_BAD];
  wire page_off_w = cfg2_reg[`B_PAGE_OFF];
  wire [2:0] res_w = cfg2_reg[`B_RES_HI:`B_RES_LO];

  // bus register updates
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
      cfg2_reg <= `CFG2_RESET;
      ctrl_reg <= 2'h0;
    end
    else
    begin
      wait_reg <= ~(req_w & wait_reg);
      if (avs_read_in & wait_reg)
        rdata_reg <= rd_mux_w;
      if (wr_cfg_w)
        cfg2_reg <= avs_writedata_in[15:0];
      if (wr_ctrl_w)
        ctrl_reg <= avs_writedata_in[1:0];
    end
  end
  assign avs_waitrequest_out = wait_reg;
  assign avs_readdata_out = rdata_reg;

  // ----------------------------------------
  // ram parity
  // ----------------------------------------
  // parity check: a new error wins over a clear in the same cycle
  wire perr_hit_w = par_en_w & ram_rd_valid_in & (par_of(ram_rdata_in) != ram_rpar_in);
  wire clr_perr_w = wr_stat_w & avs_writedata_in[`B_PERR];
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      perr_reg <= 1'b0;
      wpar_reg <= 1'b0;
    end
    else
    begin
      perr_reg <= perr_hit_w | (perr_reg & ~clr_perr_w);
      wpar_reg <= par_of(ram_wdata_in);
    end
  end
  assign ram_wpar_out = wpar_reg;

  // ----------------------------------------
  // busy lookup
  // ----------------------------------------
  // word index from bcst flag, t/r and subaddress top bit
  wire bcst_w = cmd_word_in[`CMD_ADDR_HI:`CMD_ADDR_LO] == `BCST_ADDR;
  wire [2:0] bidx_w = {bcst_w, cmd_word_in[`CMD_TR], cmd_word_in[`CMD_SA_HI]};
  wire [15:0] baddr_w = `BUSY_BASE + {13'h0000, bidx_w};
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bstate_reg <= BUSY_IDLE;
      breq_reg <= 1'b0;
      busy_rd_addr_out <= 16'h0000;
      bbit_reg <= 4'h0;
      bbit_out_reg <= 1'b0;
      bdone_reg <= 1'b0;
    end
    else
    begin
      bdone_reg <= 1'b0;
      case (bstate_reg)
        BUSY_IDLE:
          if (cmd_valid_in)
          begin
            bbit_reg <= cmd_word_in[`CMD_BIT_HI:`CMD_SA_LO];
            if (busy_en_w)
            begin
              bstate_reg <= BUSY_FETCH;
              breq_reg <= 1'b1;
              busy_rd_addr_out <= baddr_w;
            end
            else
            begin
              bbit_out_reg <= 1'b0;
              bdone_reg <= 1'b1;
            end
          end
        BUSY_FETCH:
          if (busy_rd_ack_in)
          begin
            bbit_out_reg <= busy_rd_data_in[bbit_reg];
            bdone_reg <= 1'b1;
            breq_reg <= 1'b0;
            bstate_reg <= BUSY_IDLE;
          end
        default:
          bstate_reg <= BUSY_IDLE;
      endcase
    end
  end
  assign busy_rd_req_out = breq_reg;
  assign busy_bit_out = bbit_out_reg;
  assign busy_done_out = bdone_reg;

  // ----------------------------------------
  // double buffer, pointer and rollover
  // ----------------------------------------
  // off, all, per subaddress
  wire sa_dbuf_w = sa_ctrl_in[`SA_DBUF_BIT] & (sa_ctrl_in[`MM_HI:`MM_LO] == `MM_SINGLE);
  wire dbuf_w = dbuf_en_w & (~cfg2_reg[`B_EXT_MGMT] | sa_dbuf_w);
  wire padv_w = msg_done_in & (~skip_w | msg_tx_in | msg_valid_in);
  // at boundary access; at end of good message
  wire roll_w = skip_w ? (msg_done_in & last_loc_in & (msg_tx_in | msg_valid_in))
                       : boundary_hit_in;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      dbuf_reg <= 1'b0;
      padv_reg <= 1'b0;
      roll_reg <= 1'b0;
    end
    else
    begin
      dbuf_reg <= dbuf_w;
      padv_reg <= padv_w;
      roll_reg <= roll_w;
    end
  end
  assign rx_dual_buf_out = dbuf_reg;
  assign ptr_adv_out = padv_reg;
  assign rollover_out = roll_reg;

  // ----------------------------------------
  // address stepping
  // ----------------------------------------
  // stack wraps at 256 shl size code
  wire [15:0] smask_w = 16'(16'h00ff << stack_size_in) | 16'h00ff;
  wire [15:0] inc_w = addr_cur_in + 16'h0001;
  wire [15:0] stack_w = (addr_cur_in & ~smask_w) | (inc_w & smask_w);
  wire [15:0] blk_w = page_off_w ? inc_w : {addr_cur_in[15:8], inc_w[7:0]};
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      anext_reg <= 16'h0000;
      full_reg <= 1'b0;
    end
    else
    begin
      anext_reg <= addr_stack_in ? stack_w : blk_w;
      full_reg <= rt_w & page_off_w;
    end
  end
  assign addr_next_out = anext_reg;
  assign circ_full_mem_out = full_reg;

  // ----------------------------------------
  // time tag
  // ----------------------------------------
  // external clock passes two flops; the third gives the edge
  wire ext_edge_w = tclk_reg[1] & ~tclk_reg[2];
  wire pre_end_w = (pre_reg >= period_of(res_w) - 13'h0001);
  // codes 0..5, test and external, step writes
  wire tick_w = (res_w == `RES_EXT) ? ext_edge_w :
                (res_w == `RES_TEST) ? step_reg : pre_end_w;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tclk_reg <= 3'h0;
      pre_reg <= 13'h0000;
      ttag_reg <= 16'h0000;
      step_reg <= 1'b0;
    end
    else
    begin
      tclk_reg <= {tclk_reg[1:0], tag_clk_in};
      step_reg <= wr_cmd_w & avs_writedata_in[`B_TT_STEP];
      pre_reg <= (pre_end_w | res_w[2] & res_w[1]) ? 13'h0000 : pre_reg + 13'h0001;
      if (tick_w)
        ttag_reg <= ttag_reg + 16'h0001;
    end
  end
  assign time_tag_out = ttag_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  gate_enh_a:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !enh_w |=> !rx_dual_buf_out)
    else $error("double buffer active outside enhanced mode");
  busy_off_a:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
      bstate_reg == BUSY_IDLE && cmd_valid_in && !busy_en_w |=> busy_done_out && !busy_bit_out)
    else $error("busy bit set with table disabled");
  busy_fetch_a:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
      bstate_reg == BUSY_FETCH && busy_rd_ack_in |=> busy_done_out
        && busy_bit_out == $past(busy_rd_data_in[bbit_reg]))
    else $error("busy bit not taken from table entry");
  dbuf_none_a:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !cfg2_reg[`B_DBUF_EN] |=> !rx_dual_buf_out)
    else $error("double buffer with enable clear");
  ptr_hold_a:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
      skip_w && msg_done_in && !msg_tx_in && !msg_valid_in |=> !ptr_adv_out)
    else $error("pointer advanced after invalid receive");
  ptr_all_a:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !skip_w && msg_done_in |=> ptr_adv_out)
    else $error("pointer did not advance");
  roll_now_a:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !skip_w && boundary_hit_in |=> rollover_out)
    else $error("rollover missed at boundary");
  page_wrap_a:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !page_off_w && !addr_stack_in |=> addr_next_out[15:8] == $past(addr_cur_in[15:8]))
    else $error("block address left its page");
  stack_wrap_a:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
      addr_stack_in && addr_cur_in == 16'hffff |=> addr_next_out[7:0] == 8'h00)
    else $error("stack did not wrap");
  test_step_a:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
      res_w == `RES_TEST && !step_reg |=> time_tag_out == $past(time_tag_out))
    else $error("time tag moved without test step");
endmodule : rt_buffer_and_time_tag_config
`default_nettype wire

// >>> testbench/busy_table_model.sv
// busy table memory model answering the block's busy word fetches
`timescale 1ns/10ps
`default_nettype none
module busy_table_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic [15:0] addr_in,
  input wire logic [3:0] lat_in,
  output logic ack_out,
  output logic [15:0] data_out
);
  logic [15:0] mem [0:7];
  logic [3:0] cnt_reg;
  // eight table words
  // outside an answer the data lines invert each cycle, so stale data matches only every other cycle
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg <= 4'h0;
      ack_out <= 1'b0;
      data_out <= 16'h5a5a;
    end
    else if (req_in && !ack_out && cnt_reg == lat_in)
    begin
      cnt_reg <= 4'h0;
      ack_out <= 1'b1;
      data_out <= mem[addr_in[2:0]];
    end
    else
    begin
      cnt_reg <= (req_in && !ack_out) ? cnt_reg + 4'h1 : 4'h0;
      ack_out <= 1'b0;
      data_out <= ~data_out;
    end
  end
endmodule : busy_table_model
`default_nettype wire

// >>> testbench/rt_buffer_and_time_tag_config_tb.sv
// self-checking bench for the buffer and time tag configuration block
`timescale 1ns/10ps
`default_nettype none
`include "rtcfg_defines.svh"
module rt_buffer_and_time_tag_config_tb;
  import rtcfg_pkg::*;
  logic clk_in = 0, rst_n_in = 0, avs_read_in = 0, avs_write_in = 0;
  logic [4:0] avs_address_in = 0;
  logic [31:0] avs_writedata_in = 0, avs_readdata_out, rd;
  logic avs_waitrequest_out, cmd_valid_in = 0, busy_rd_req_out, busy_rd_ack_in;
  logic [15:0] cmd_word_in = 0, busy_rd_addr_out, addr_next_out, time_tag_out, t0;
  logic busy_bit_out, busy_done_out, rx_dual_buf_out, ptr_adv_out, rollover_out;
  word_t busy_rd_data_in, sa_ctrl_in = 0, addr_cur_in = 0, ram_wdata_in = 0;
  word_t ram_rdata_in = 0;
  logic msg_done_in = 0, msg_tx_in = 0, msg_valid_in = 0, boundary_hit_in = 0;
  logic last_loc_in = 0, addr_stack_in = 0, circ_full_mem_out, ram_wpar_out;
  logic ram_rd_valid_in = 0, ram_rpar_in = 0, tag_clk_in = 0;
  logic [1:0] stack_size_in = 0;
  logic [3:0] lat_in = 0;
  int failures = 0, num_checks = 0;
  // short divider keeps the time tag runs brief
  rt_buffer_and_time_tag_config #(.TICK_FINEST_CYCLES(4)) i_dut (.clk_in, .rst_n_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
    .avs_waitrequest_out, .cmd_valid_in, .cmd_word_in, .busy_rd_req_out, .busy_rd_addr_out,
    .busy_rd_ack_in, .busy_rd_data_in, .busy_bit_out, .busy_done_out, .sa_ctrl_in,
    .rx_dual_buf_out, .msg_done_in, .msg_tx_in, .msg_valid_in, .boundary_hit_in,
    .last_loc_in, .ptr_adv_out, .rollover_out, .addr_cur_in, .addr_stack_in,
    .stack_size_in, .addr_next_out, .circ_full_mem_out, .ram_wdata_in, .ram_wpar_out,
    .ram_rd_valid_in, .ram_rdata_in, .ram_rpar_in, .tag_clk_in, .time_tag_out);
  busy_table_model i_ram (.clk_in, .rst_n_in, .req_in(busy_rd_req_out),
    .addr_in(busy_rd_addr_out), .lat_in, .ack_out(busy_rd_ack_in),
    .data_out(busy_rd_data_in));
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // a hang counts as a mismatch and ends the run
  initial
  begin
    #200000;
    failures++;
    print_verdict();
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // avalon cycle held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    do
    begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    // exactly one wait state per access; a hang is left to the watchdog
    chk("wait_states", n, 2);
    @(posedge clk_in);
  endtask : bus
  task automatic cmd(input logic [15:0] w, input logic [15:0] ea, input logic eb);
    int n;
    logic [15:0] a;
    n = 0;
    a = 16'hffff;
    cmd_word_in <= w;
    cmd_valid_in <= 1'b1;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    do
    begin
      @(posedge clk_in);
      n++;
      if (busy_rd_req_out === 1'b1)
        a = busy_rd_addr_out;
    end while (busy_done_out !== 1'b1 && n < 40);
    chk("busy_done", n < 40, 1);
    chk("busy_addr", a, ea);
    chk("busy_bit", busy_bit_out, eb);
  endtask : cmd
  task automatic db(input logic [31:0] c, input logic [15:0] s, input logic e);
    bus(1, `OFS_CFG2, c);
    sa_ctrl_in <= s;
    repeat (2) @(posedge clk_in);
    chk("dual_buf", rx_dual_buf_out, e);
  endtask : db
  // v is done, tx, valid, boundary hit, last location
  task automatic msg(input logic [4:0] v, input logic [1:0] e);
    {msg_done_in, msg_tx_in, msg_valid_in, boundary_hit_in, last_loc_in} <= v;
    @(posedge clk_in);
    msg_done_in <= 1'b0;
    boundary_hit_in <= 1'b0;
    @(posedge clk_in);
    chk("ptr_adv", ptr_adv_out, e[1]);
    chk("rollover", rollover_out, e[0]);
  endtask : msg
  task automatic ad(input logic [15:0] c, input logic s, input logic [1:0] z,
    input logic [16:0] e);
    addr_cur_in <= c;
    addr_stack_in <= s;
    stack_size_in <= z;
    repeat (2) @(posedge clk_in);
    chk("addr_next", addr_next_out, e[15:0]);
    chk("full_mem", circ_full_mem_out, e[16]);
  endtask : ad
  // settle first so a code change mid-period does not skew the count
  task automatic tt(input int n, input logic [15:0] e);
    repeat (n) @(posedge clk_in);
    t0 = time_tag_out;
    repeat (n) @(posedge clk_in);
    chk("time_tag", time_tag_out - t0, e);
  endtask : tt
  initial
  begin
    for (int i = 0; i < 8; i++)
      i_ram.mem[i] = (i == 0 || i == 7) ? 16'h0008 : 16'h0000;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    bus(0, `OFS_CFG2, 0);
    chk("cfg2_reset", rd, 32'h0000);
    bus(1, `OFS_CFG2, 32'h7f82);
    bus(0, `OFS_CFG2, 0);
    chk("cfg2_rw", rd, 32'h7f82);
    bus(0, 5'h14, 0);
    chk("unmapped", rd, 32'h0000);
    $display("test registers done");
    // parity only with extra bit: this bench models the large-memory part
    bus(1, `OFS_CTRL, 32'h1);
    bus(1, `OFS_CFG2, 32'h4000);
    ram_wdata_in <= 16'h0007;
    repeat (2) @(posedge clk_in);
    chk("wpar", ram_wpar_out, 1);
    ram_rdata_in <= 16'h0001;
    ram_rd_valid_in <= 1'b1;
    @(posedge clk_in);
    ram_rd_valid_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    bus(0, `OFS_STAT, 0);
    chk("perr", rd, 32'h1);
    bus(1, `OFS_STAT, 32'h1);
    bus(0, `OFS_STAT, 0);
    chk("perr_clr", rd, 32'h0);
    $display("test parity done");
    bus(1, `OFS_CFG2, 32'h2000);
    cmd(16'h2860, 16'h0240, 1);
    lat_in <= 4'h3;
    cmd(16'h2880, 16'h0240, 0);
    cmd(16'hfe60, 16'h0247, 1);
    bus(1, `OFS_CFG2, 32'h0);
    cmd(16'h2860, 16'hffff, 0);
    bus(1, `OFS_CTRL, 32'h0);
    bus(1, `OFS_CFG2, 32'h2000);
    cmd(16'h2860, 16'hffff, 0);
    $display("test busy table done");
    bus(1, `OFS_CTRL, 32'h1);
    db(32'h1000, 16'h0000, 1);
    db(32'h0000, 16'h8000, 0);
    db(32'h1002, 16'h8000, 1);
    db(32'h1002, 16'h8001, 0);
    db(32'h1002, 16'h0000, 0);
    bus(1, `OFS_CTRL, 32'h0);
    db(32'h1000, 16'h0000, 0);
    $display("test double buffer done");
    bus(1, `OFS_CFG2, 32'h0);
    msg(5'b10000, 2'b10);
    msg(5'b00010, 2'b01);
    bus(1, `OFS_CFG2, 32'h0800);
    msg(5'b10000, 2'b00);
    msg(5'b10100, 2'b10);
    msg(5'b11000, 2'b10);
    msg(5'b00010, 2'b00);
    msg(5'b10101, 2'b11);
    msg(5'b10001, 2'b00);
    msg(5'b11001, 2'b11);
    $display("test circular pointer done");
    // terminal starts with page wrap on
    bus(1, `OFS_CTRL, 32'h3);
    bus(1, `OFS_CFG2, 32'h0);
    ad(16'h12ff, 0, 2'h0, 17'h01200);
    bus(1, `OFS_CFG2, 32'h0400);
    ad(16'h12ff, 0, 2'h0, 17'h11300);
    ad(16'h12ff, 1, 2'h0, 17'h11200);
    ad(16'h13ff, 1, 2'h1, 17'h11200);
    ad(16'h17ff, 1, 2'h3, 17'h11000);
    ad(16'h12ff, 1, 2'h3, 17'h11300);
    ad(16'hffff, 1, 2'h0, 17'h1ff00);
    bus(1, `OFS_CTRL, 32'h1);
    ad(16'h12ff, 0, 2'h0, 17'h01300);
    $display("test addressing done");
    for (int c = 5; c >= 0; c--)
    begin
      bus(1, `OFS_CFG2, c << 7);
      tt(8 << (5 - c), 16'h2);
    end
    bus(1, `OFS_CFG2, 32'h0300);
    tt(20, 16'h0);
    t0 = time_tag_out;
    bus(1, `OFS_CMD, 32'h10);
    bus(1, `OFS_CMD, 32'h00);
    bus(1, `OFS_CMD, 32'h10);
    repeat (4) @(posedge clk_in);
    chk("tt_step", time_tag_out - t0, 16'h2);
    bus(1, `OFS_CFG2, 32'h0380);
    t0 = time_tag_out;
    repeat (3)
    begin
      tag_clk_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      tag_clk_in <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    chk("tt_ext", time_tag_out - t0, 16'h3);
    $display("test time tag done");
    print_verdict();
  end
endmodule : rt_buffer_and_time_tag_config_tb
`default_nettype wire
